// >>> pfhost_regs.vh
// constants for the parallel flash host controller
// assumes a 200 MHz core clock and an x8 flash with 19 address lines at most
`ifndef PFHOST_REGS_VH
`define PFHOST_REGS_VH
`define PFH_ADDR_W 19
`define PFH_UNLOCK_ADDR1 19'h05555
`define PFH_UNLOCK_ADDR2 19'h02AAA
`define PFH_UNLOCK_DATA1 8'hAA
`define PFH_UNLOCK_DATA2 8'h55
`define PFH_PROGRAM_CMD 8'hA0
`define PFH_CLK_PERIOD_NS 5
`define PFH_ACCESS_NS 70
`define PFH_ACCESS_CYC ((`PFH_ACCESS_NS + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)
`define PFH_WE_PULSE_NS 40
`define PFH_WE_PULSE_CYC ((`PFH_WE_PULSE_NS + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)
`define PFH_GAP_NS 30
`define PFH_GAP_CYC ((`PFH_GAP_NS + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)
`define PFH_PROG_MAX_US 20
`define PFH_PROG_MAX_CYC (`PFH_PROG_MAX_US * 1000 / `PFH_CLK_PERIOD_NS)
`endif

// >>> pfhost_ctrl.v
// host-side controller for an x8 parallel flash: byte reads and byte program
// assumes the flash pins connect directly; byte_lines is split into in/out/enable
`timescale 1ns/10ps
`include "pfhost_regs.vh"

// Behaviour
// (R1) a command is written with write strobe low while chip select is low
// (R2) flash latches address at the later falling edge of strobe or select
// (R3) flash latches data at the earlier rising edge of strobe or select
// (R4) reads hold chip select and output gate low, then sample byte lines
// (R5) chip select high deselects the flash; bus is idle then
// (R6) flash floats byte lines when select or gate is high
// (R7) one byte per program; target sector must already be erased
// (R8) program is three unlock writes then one address and data write
// (R9) internal program starts after the fourth write ends
// (R10) internal program finishes within 20 microseconds
// (R11) reads during program return status only, never array data
// (R12) flash ignores commands written during internal program
// (R13) sector erase selects the sector by address bits top line down to A12
// (R14) array is 128K, 256K or 512K bytes; top address line A16 to A18
// (R15) unlock is AA to 5555, 55 to 2AAA, A0 to 5555
// (R16) during program the inverted poll line shows the complement of the data
// (R17) during program the alternating status line toggles on each read
// (R18) a mismatched unlock write aborts the sequence to read mode
// (R19) after program the flash returns to read mode
module pfhost_ctrl (
    input wire core_clk,
    input wire rst_n,
    input wire req_valid,
    input wire req_write,
    input wire [18:0] req_addr,
    input wire [7:0] req_wdata,
    output reg req_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_rdata,
    output reg rsp_error,
    output reg [18:0] flash_addr,
    output reg chip_select_n,
    output reg output_gate_n,
    output reg write_strobe_n,
    input wire [7:0] byte_lines_in,
    output reg [7:0] byte_lines_out,
    output reg byte_lines_oe
);
    localparam ST_IDLE = 3'h0;
    localparam ST_RD = 3'h1;
    localparam ST_WR = 3'h2;
    localparam ST_GAP = 3'h3;
    localparam ST_POLL = 3'h4;
    localparam ST_PGAP = 3'h5;

    reg [2:0] state_reg;
    reg [1:0] step_reg;
    reg [15:0] cnt_reg;
    reg [15:0] tmo_reg;
    reg [18:0] tgt_addr_reg;
    reg [7:0] tgt_data_reg;
    reg [7:0] s1_reg;
    reg [7:0] s2_reg;
    reg [7:0] s3_reg;
    reg [7:0] last_reg;
    reg have_last_reg;

    // pins are asynchronous to core_clk: three stages, the last two must agree
    wire [7:0] rd_byte = s3_reg;
    wire rd_stable = (s2_reg == s3_reg);

    reg [18:0] step_addr;
    reg [7:0] step_data;
    always @* begin
        case (step_reg)
            2'h0: begin
                step_addr = `PFH_UNLOCK_ADDR1;
                step_data = `PFH_UNLOCK_DATA1;
            end
            2'h1: begin
                step_addr = `PFH_UNLOCK_ADDR2;
                step_data = `PFH_UNLOCK_DATA2;
            end
            2'h2: begin
                step_addr = `PFH_UNLOCK_ADDR1;
                step_data = `PFH_PROGRAM_CMD;
            end
            default: begin
                step_addr = tgt_addr_reg;
                step_data = tgt_data_reg;
            end
        endcase
    end

    always @(posedge core_clk) begin
        s1_reg <= byte_lines_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            step_reg <= 2'h0;
            cnt_reg <= 16'h0000;
            tmo_reg <= 16'h0000;
            tgt_addr_reg <= 19'h00000;
            tgt_data_reg <= 8'h00;
            last_reg <= 8'h00;
            have_last_reg <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_error <= 1'b0;
            flash_addr <= 19'h00000;
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            write_strobe_n <= 1'b1;
            byte_lines_out <= 8'h00;
            byte_lines_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    chip_select_n <= 1'b1; // see (R5)
                    output_gate_n <= 1'b1;
                    write_strobe_n <= 1'b1;
                    byte_lines_oe <= 1'b0;
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        cnt_reg <= 16'h0000;
                        if (req_write) begin
                            // one byte per program; erase is the caller's job, see (R7)
                            tgt_addr_reg <= req_addr;
                            tgt_data_reg <= req_wdata;
                            step_reg <= 2'h0;
                            tmo_reg <= 16'h0000;
                            state_reg <= ST_WR;
                        end else begin
                            flash_addr <= req_addr;
                            chip_select_n <= 1'b0; // see (R4)
                            output_gate_n <= 1'b0;
                            state_reg <= ST_RD;
                        end
                    end
                end
                ST_RD: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    // three extra cycles cover the pin synchroniser
                    if (cnt_reg >= `PFH_ACCESS_CYC + 3 && rd_stable) begin
                        rsp_rdata <= rd_byte;
                        rsp_error <= 1'b0;
                        rsp_valid <= 1'b1;
                        chip_select_n <= 1'b1;
                        output_gate_n <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_WR: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == 16'h0000) begin
                        // address settles with strobes high; gate stays high so the flash floats, see (R6)
                        flash_addr <= step_addr;
                        byte_lines_out <= step_data; // see (R15)
                        byte_lines_oe <= 1'b1;
                        output_gate_n <= 1'b1;
                    end else if (cnt_reg == 16'h0001) begin
                        // select then strobe: strobe falls last and latches the address, see (R2)
                        chip_select_n <= 1'b0;
                    end else if (cnt_reg == 16'h0002) begin
                        write_strobe_n <= 1'b0; // see (R1)
                    end else if (cnt_reg == `PFH_WE_PULSE_CYC + 2) begin
                        // strobe rises first and latches the data, see (R3)
                        write_strobe_n <= 1'b1;
                    end else if (cnt_reg > `PFH_WE_PULSE_CYC + 2) begin
                        chip_select_n <= 1'b1;
                        cnt_reg <= 16'h0000;
                        state_reg <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    byte_lines_oe <= 1'b0;
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg >= `PFH_GAP_CYC) begin
                        cnt_reg <= 16'h0000;
                        if (step_reg == 2'h3) begin
                            // fourth write done: internal program running, see (R9)
                            have_last_reg <= 1'b0;
                            state_reg <= ST_POLL;
                        end else begin
                            step_reg <= step_reg + 2'h1; // see (R8)
                            state_reg <= ST_WR;
                        end
                    end
                end
                ST_POLL: begin
                    // no writes are issued while programming, see (R12)
                    tmo_reg <= tmo_reg + 16'h0001;
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == 16'h0000) begin
                        flash_addr <= tgt_addr_reg;
                        chip_select_n <= 1'b0;
                        output_gate_n <= 1'b0;
                    end else if (cnt_reg >= `PFH_ACCESS_CYC + 3 && rd_stable) begin
                        chip_select_n <= 1'b1;
                        output_gate_n <= 1'b1;
                        cnt_reg <= 16'h0000;
                        last_reg <= rd_byte;
                        have_last_reg <= 1'b1;
                        // status reads are never returned as data, see (R11)
                        // done when the alternating line stops and poll line is true, see (R16) (R17)
                        if (have_last_reg && rd_byte[6] == last_reg[6] && rd_byte[7] == tgt_data_reg[7]) begin
                            rsp_error <= 1'b0;
                            rsp_valid <= 1'b1;
                            state_reg <= ST_IDLE; // flash back in read mode, see (R19)
                        end else if (tmo_reg >= `PFH_PROG_MAX_CYC) begin
                            // past the longest program time, see (R10)
                            rsp_error <= 1'b1;
                            rsp_valid <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_PGAP;
                        end
                    end
                end
                ST_PGAP: begin
                    // select must go high between reads so the status line toggles
                    tmo_reg <= tmo_reg + 16'h0001;
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg >= `PFH_GAP_CYC) begin
                        cnt_reg <= 16'h0000;
                        state_reg <= ST_POLL;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> pfhost_flash_model.sv
// behavioural x8 flash standing on the host controller pins
// hang holds an internal program open until released
`timescale 1ns/10ps
`include "pfhost_regs.vh"
module pfhost_flash_model #(
    parameter integer PROG_NS = 14000
) (
    input wire [18:0] flash_addr,
    input wire chip_select_n,
    input wire output_gate_n,
    input wire write_strobe_n,
    input wire byte_lines_oe,
    input wire hang,
    input wire [7:0] byte_lines_out,
    output wire [7:0] byte_lines_in
);
    localparam [26:0] U1 = {`PFH_UNLOCK_ADDR1, `PFH_UNLOCK_DATA1};
    localparam [26:0] U2 = {`PFH_UNLOCK_ADDR2, `PFH_UNLOCK_DATA2};
    localparam [26:0] U3 = {`PFH_UNLOCK_ADDR1, `PFH_PROGRAM_CMD};
    reg [7:0] mem [0:524287];
    reg [18:0] lat_addr, prog_addr;
    reg [7:0] prog_data, float_val = 8'h3C;
    reg [1:0] step = 2'h0;
    reg busy = 1'b0, tog = 1'b0;
    wire wr_n = chip_select_n | write_strobe_n;
    wire rd_n = chip_select_n | output_gate_n;
    wire [26:0] cyc = {lat_addr, byte_lines_out};
    wire [7:0] rd = busy ? {~prog_data[7], tog, 6'h15} : mem[flash_addr];
    // a released bus keeps moving so a stale byte never reads as good
    assign #55 byte_lines_in = !rd_n ? rd : (byte_lines_oe ? byte_lines_out : ~float_val);
    // starts erased, one 4 Kbyte sector at a time; the sector is picked by line 12 and the lines above it
    initial for (int s = 0; s < 128; s++) for (int i = 0; i < 4096; i++) mem[{s[6:0], i[11:0]}] = 8'hFF;
    always @(byte_lines_in) float_val = byte_lines_in;
    always @(negedge wr_n) lat_addr = flash_addr;
    always @(posedge rd_n) if (busy) tog = ~tog;
    always @(posedge wr_n) begin
        if (!busy) begin
            case (step)
                2'h0: step = {1'b0, cyc === U1};
                2'h1: step = {cyc === U2, 1'b0};
                2'h2: step = {2{cyc === U3}};
                default: begin
                    prog_addr = lat_addr;
                    prog_data = byte_lines_out;
                    busy = 1'b1;
                    step = 2'h0;
                end
            endcase
        end
    end
    // a cell can only lose bits until erased
    always @(posedge busy) begin
        #(PROG_NS);
        wait (!hang);
        mem[prog_addr] = mem[prog_addr] & prog_data;
        busy = 1'b0;
    end
endmodule

// >>> pfhost_ctrl_monitor.sv
// assertions on the flash host controller pins
// bound into every pfhost_ctrl; sees its ports only
`timescale 1ns/10ps
module pfhost_ctrl_monitor (
    input wire core_clk,
    input wire rst_n,
    input wire req_valid,
    input wire req_write,
    input wire req_ready,
    input wire rsp_valid,
    input wire rsp_error,
    input wire [18:0] req_addr,
    input wire [18:0] flash_addr,
    input wire [7:0] req_wdata,
    input wire [7:0] rsp_rdata,
    input wire [7:0] byte_lines_in,
    input wire [7:0] byte_lines_out,
    input wire chip_select_n,
    input wire output_gate_n,
    input wire write_strobe_n,
    input wire byte_lines_oe
);
    localparam int PROG_LIMIT = 4400;
    reg prog_on;
    reg [12:0] prog_cnt;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence strobe_low;
        (!write_strobe_n && !chip_select_n && $stable(flash_addr)) [*8];
    endsequence
    always @(posedge core_clk) begin
        if (!rst_n || rsp_valid) prog_on <= 1'b0;
        else if (req_valid && req_ready && req_write) prog_on <= 1'b1;
        prog_cnt <= prog_on ? prog_cnt + 13'h0001 : 13'h0000;
    end
    strobe_sel_a: assert property (!write_strobe_n |-> !chip_select_n) else $error("strobe without select");
    strobe_hold_a: assert property ($fell(write_strobe_n) |-> strobe_low) else $error("strobe pulse broken");
    data_hold_a: assert property ($rose(write_strobe_n) |-> !chip_select_n && byte_lines_oe && $stable(byte_lines_out))
        else $error("data moved at strobe end");
    gate_sel_a: assert property (!output_gate_n |-> !chip_select_n) else $error("gate without select");
    no_fight_a: assert property (byte_lines_oe |-> output_gate_n) else $error("bus driven during read");
    idle_park_a: assert property (req_ready |-> chip_select_n && write_strobe_n && !byte_lines_oe)
        else $error("bus active in idle");
    busy_hold_a: assert property (prog_on |-> !req_ready) else $error("request taken during program");
    prog_bound_a: assert property (prog_cnt < PROG_LIMIT) else $error("program answer late");
    ready_back_a: assert property (rsp_valid |=> req_ready) else $error("ready not back");
endmodule
bind pfhost_ctrl pfhost_ctrl_monitor mon (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req_write(req_write),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .rsp_error(rsp_error),
    .req_addr(req_addr),
    .flash_addr(flash_addr),
    .req_wdata(req_wdata),
    .rsp_rdata(rsp_rdata),
    .byte_lines_in(byte_lines_in),
    .byte_lines_out(byte_lines_out),
    .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n),
    .byte_lines_oe(byte_lines_oe)
);

// >>> pfhost_ctrl_tb.sv
// self-checking bench for the flash host controller
// a behavioural flash model stands on the pins
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module pfhost_ctrl_tb;
    reg core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, hang = 1'b0, got_err;
    reg [18:0] req_addr = 19'h00000;
    reg [7:0] req_wdata = 8'h00, got_data;
    integer num_errors = 0, total_checks = 0;
    wire req_ready, rsp_valid, rsp_error, chip_select_n, output_gate_n, write_strobe_n, byte_lines_oe;
    wire [18:0] flash_addr;
    wire [7:0] rsp_rdata, byte_lines_in, byte_lines_out;
    pfhost_ctrl uut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .req_valid(req_valid),
        .req_write(req_write),
        .req_addr(req_addr),
        .req_wdata(req_wdata),
        .req_ready(req_ready),
        .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata),
        .rsp_error(rsp_error),
        .flash_addr(flash_addr),
        .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n),
        .byte_lines_in(byte_lines_in),
        .byte_lines_out(byte_lines_out),
        .byte_lines_oe(byte_lines_oe)
    );
    pfhost_flash_model flash (
        .flash_addr(flash_addr),
        .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n),
        .byte_lines_oe(byte_lines_oe),
        .hang(hang),
        .byte_lines_out(byte_lines_out),
        .byte_lines_in(byte_lines_in)
    );
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task xfer(input reg w, input reg [18:0] a, input reg [7:0] d);
        integer n;
        n = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(negedge core_clk);
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(negedge core_clk);
        while (rsp_valid !== 1'b1 && n < 6000) begin
            @(negedge core_clk);
            n = n + 1;
        end
        // a missing answer counts as a mismatch; the stale byte on rsp_rdata is still handed back
        `CHK("answer pulse", 1'b1, rsp_valid)
        got_data = rsp_rdata;
        got_err = rsp_error;
    endtask
    task t_program;
        xfer(1'b1, 19'h7F012, 8'h5A);
        `CHK("program flag", 1'b0, got_err)
        xfer(1'b0, 19'h7F012, 8'h00);
        `CHK("programmed byte", 8'h5A, got_data)
        xfer(1'b0, 19'h7F013, 8'h00);
        `CHK("neighbour byte", 8'hFF, got_data)
        $display("test program done");
    endtask
    task t_twice;
        // back-to-back programs into erased cells; a cell is never programmed twice without an erase
        xfer(1'b1, 19'h00000, 8'h0F);
        `CHK("first flag", 1'b0, got_err)
        xfer(1'b1, 19'h00001, 8'hF3);
        `CHK("second flag", 1'b0, got_err)
        xfer(1'b0, 19'h00000, 8'h00);
        `CHK("first byte", 8'h0F, got_data)
        xfer(1'b0, 19'h00001, 8'h00);
        `CHK("second byte", 8'hF3, got_data)
        $display("test twice done");
    endtask
    task t_stuck;
        hang <= 1'b1;
        xfer(1'b1, 19'h12345, 8'hA5);
        `CHK("timeout flag", 1'b1, got_err)
        hang <= 1'b0;
        repeat (4) @(posedge core_clk);
        xfer(1'b0, 19'h12345, 8'h00);
        `CHK("late byte", 8'hA5, got_data)
        $display("test stuck done");
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_program;
        t_twice;
        t_stuck;
        wrap_up;
    end
    // about six times the longest expected run
    initial begin
        #400000;
        num_errors++;
        $display("BAD watchdog exp done got hung");
        wrap_up;
    end
endmodule
